//--- verilog/fault_supervisor_defines.vh
/*
 Fatal-fault supervisor constants: fault codes, timing windows, widths.
 Assumes a 10 MHz system clock; included by the supervisor modules.
*/
`ifndef FAULT_SUPERVISOR_DEFINES_VH
`define FAULT_SUPERVISOR_DEFINES_VH

// Clock rate in Hz
`define CLK_HZ 10000000

// Fault codes, 10 bits; hex of the decimal fault numbers 912 to 995
`define FC_NONE 10'h000
`define FC_CHOPPER_OPEN 10'h390
`define FC_DC_HIGH 10'h391
`define FC_ENC_MISSING 10'h392
`define FC_ENC_LOST 10'h394
`define FC_RESISTOR_ON 10'h395
`define FC_BRAKE_MON_DROP 10'h397
`define FC_OVERCURRENT 10'h398
`define FC_STAGE_ERROR 10'h3A3
`define FC_TRAVEL_LIMIT 10'h3B6
`define FC_STO_DIAG 10'h3C0
`define FC_STO_HW 10'h3C1
`define FC_IPC_TRAVEL 10'h3DF
`define FC_ENC_DIFF 10'h3E1
`define FC_IPC_STANDSTILL 10'h3E2
`define FC_ENC_CD_LIMIT 10'h3E3

// Timing windows in ms, as printed
`define DC_HIGH_MS 5000
`define RESISTOR_ON_MS 5500
`define STO_DISAGREE_MS 310
`define IPC_LOSS_MS 7500

// Cycle counts: least times round up, "more than" adds one cycle
`define DC_HIGH_CYC ((`DC_HIGH_MS * (`CLK_HZ / 1000)))
`define RESISTOR_ON_CYC ((`RESISTOR_ON_MS * (`CLK_HZ / 1000)))
`define STO_DISAGREE_CYC ((`STO_DISAGREE_MS * (`CLK_HZ / 1000)))
`define IPC_LOSS_CYC ((`IPC_LOSS_MS * (`CLK_HZ / 1000)) + 1)

// Number of fault sources, bit positions in the pending vector
`define NUM_FAULTS 15
`define BIT_912 0
`define BIT_913 1
`define BIT_914 2
`define BIT_916 3
`define BIT_917 4
`define BIT_919 5
`define BIT_920 6
`define BIT_931 7
`define BIT_950 8
`define BIT_960 9
`define BIT_961 10
`define BIT_991 11
`define BIT_993 12
`define BIT_994 13
`define BIT_995 14

`endif

//--- verilog/window_timer.v
/*
 Qualified-duration timer: raises expired once a condition has held for LIMIT cycles and holds it until the condition drops.
 Assumes a synchronous active-low reset and a condition synchronous to clk.
*/
`include "fault_supervisor_defines.vh"

module window_timer #(
	parameter WIDTH = 27,
	parameter LIMIT = 50000000
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Monitored condition and expiry
	input wire cond,
	output reg expired
);

	reg [WIDTH-1:0] count_reg;

	// Count while the condition holds; restart whenever it drops
	always @(posedge clk) begin
		if (!rst_n) begin
			count_reg <= {WIDTH{1'b0}};
			expired <= 1'b0;
		end else if (!cond) begin
			count_reg <= {WIDTH{1'b0}};
			expired <= 1'b0;
		end else begin
			if (count_reg != LIMIT[WIDTH-1:0]) begin
				count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
			end
			// Reaching the limit after LIMIT held cycles
			expired <= (count_reg == LIMIT[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1}) ||
				(count_reg == LIMIT[WIDTH-1:0]);
		end
	end

endmodule

//--- verilog/fatal_fault_supervisor.v
/*
 Fatal-fault supervisor for a lift-drive inverter: watches contacts, encoder,
 safe-torque-off channels, DC link, brake transistor and processor links and
 latches numbered fatal faults that inhibit travel.
 Assumes all inputs are synchronous to clk; rst_n is the reset request, while
 power_on_rst_n is the power-up reset that alone clears the sticky faults.
*/
`include "fault_supervisor_defines.vh"

module fatal_fault_supervisor #(
	parameter POS_WIDTH = 24,
	parameter POS_TOLERANCE = 24'h000100,
	parameter CNT_WIDTH = 27,
	parameter DC_HIGH_CYCLES = `DC_HIGH_CYC,
	parameter RESISTOR_ON_CYCLES = `RESISTOR_ON_CYC,
	parameter STO_DISAGREE_CYCLES = `STO_DISAGREE_CYC,
	parameter IPC_LOSS_CYCLES = `IPC_LOSS_CYC
) (
	// Clock and resets
	input wire clk,
	input wire rst_n,
	input wire power_on_rst_n,
	// Operating state
	input wire inverter_operating,
	input wire travel_active,
	input wire travel_start_req,
	input wire startup_check,
	// Brake chopper and DC link
	input wire chopper_monitor_closed,
	input wire dc_link_above_trigger,
	input wire braking_resistor_on,
	input wire brake_monitor_input,
	// Power stage
	input wire overcurrent,
	input wire stage_error,
	// Encoder port
	input wire encoder_present,
	input wire encoder_signal_ok,
	input wire abs_pos_valid,
	input wire [POS_WIDTH-1:0] abs_pos_new,
	input wire [POS_WIDTH-1:0] abs_pos_stored,
	input wire track_c_in_limit,
	input wire track_d_in_limit,
	// Safe torque off
	input wire safe_torque_off_ch_a,
	input wire safe_torque_off_ch_b,
	input wire sto_hw_fail,
	// Processor links
	input wire ipc_ok,
	input wire mgmt_link_ok,
	// Travel down counter
	input wire travel_down_counter_at_limit,
	// Fault outputs
	output reg [9:0] fault_code,
	output reg [`NUM_FAULTS-1:0] fault_flags,
	output reg travel_inhibit,
	output reg sto_switch_off,
	output reg [POS_WIDTH-1:0] pos_diff,
	output reg last_travel_granted
);

	// Absolute distance between two positions
	function [POS_WIDTH-1:0] abs_diff;
		input [POS_WIDTH-1:0] a;
		input [POS_WIDTH-1:0] b;
		begin
			if (a > b) begin
				abs_diff = a - b;
			end else begin
				abs_diff = b - a;
			end
		end
	endfunction

	// Pick the code of the lowest set fault bit
	function [9:0] code_of;
		input [`NUM_FAULTS-1:0] f;
		begin
			code_of = `FC_NONE;
			// Later tests win, so the lowest fault number shows first
			if (f[`BIT_995]) begin
				code_of = `FC_ENC_CD_LIMIT;
			end
			if (f[`BIT_994]) begin
				code_of = `FC_IPC_STANDSTILL;
			end
			if (f[`BIT_993]) begin
				code_of = `FC_ENC_DIFF;
			end
			if (f[`BIT_991]) begin
				code_of = `FC_IPC_TRAVEL;
			end
			if (f[`BIT_961]) begin
				code_of = `FC_STO_HW;
			end
			if (f[`BIT_960]) begin
				code_of = `FC_STO_DIAG;
			end
			if (f[`BIT_950]) begin
				code_of = `FC_TRAVEL_LIMIT;
			end
			if (f[`BIT_931]) begin
				code_of = `FC_STAGE_ERROR;
			end
			if (f[`BIT_920]) begin
				code_of = `FC_OVERCURRENT;
			end
			if (f[`BIT_919]) begin
				code_of = `FC_BRAKE_MON_DROP;
			end
			if (f[`BIT_917]) begin
				code_of = `FC_RESISTOR_ON;
			end
			if (f[`BIT_916]) begin
				code_of = `FC_ENC_LOST;
			end
			if (f[`BIT_914]) begin
				code_of = `FC_ENC_MISSING;
			end
			if (f[`BIT_913]) begin
				code_of = `FC_DC_HIGH;
			end
			if (f[`BIT_912]) begin
				code_of = `FC_CHOPPER_OPEN;
			end
		end
	endfunction

	// Last-travel sequencer states, one-hot
	localparam LT_IDLE = 3'b001;
	localparam LT_ARMED = 3'b010;
	localparam LT_USED = 3'b100;

	// Faults that only a power-up reset clears; a reset request must not hide them
	localparam [`NUM_FAULTS-1:0] STICKY_MASK = (15'h0001 << `BIT_960) |
		(15'h0001 << `BIT_961) | (15'h0001 << `BIT_995) |
		(15'h0001 << `BIT_931);

	wire dc_expired;
	wire resistor_expired;
	wire sto_expired;
	wire ipc_expired;
	reg travel_d_reg;
	reg after_travel_reg;
	reg startup_d_reg;
	reg [2:0] lt_reg;
	reg [2:0] lt_next;
	reg [`NUM_FAULTS-1:0] event_vec;
	reg [`NUM_FAULTS-1:0] flags_next;
	reg [POS_WIDTH-1:0] diff_now;
	wire clear_n;

	// Timers and edge trackers restart on either reset, so no window runs across power-up
	assign clear_n = rst_n && power_on_rst_n;

	// Standstill DC-link over trigger window
	window_timer #(
		.WIDTH(CNT_WIDTH),
		.LIMIT(DC_HIGH_CYCLES)
	) dc_timer (
		.clk(clk),
		.rst_n(clear_n),
		.cond(!travel_active && dc_link_above_trigger),
		.expired(dc_expired)
	);

	// Resistor transistor on after travel end
	window_timer #(
		.WIDTH(CNT_WIDTH),
		.LIMIT(RESISTOR_ON_CYCLES)
	) resistor_timer (
		.clk(clk),
		.rst_n(clear_n),
		.cond(after_travel_reg && braking_resistor_on),
		.expired(resistor_expired)
	);

	// Channel disagreement window
	window_timer #(
		.WIDTH(CNT_WIDTH),
		.LIMIT(STO_DISAGREE_CYCLES)
	) sto_timer (
		.clk(clk),
		.rst_n(clear_n),
		.cond(safe_torque_off_ch_a != safe_torque_off_ch_b),
		.expired(sto_expired)
	);

	// Standstill processor link loss window
	window_timer #(
		.WIDTH(CNT_WIDTH),
		.LIMIT(IPC_LOSS_CYCLES)
	) ipc_timer (
		.clk(clk),
		.rst_n(clear_n),
		.cond(!travel_active && !mgmt_link_ok),
		.expired(ipc_expired)
	);

	// Travel edge tracking; after-travel stays set until next travel
	always @(posedge clk) begin
		if (!clear_n) begin
			travel_d_reg <= 1'b0;
			after_travel_reg <= 1'b0;
			startup_d_reg <= 1'b0;
		end else begin
			travel_d_reg <= travel_active;
			startup_d_reg <= startup_check;
			if (travel_active) begin
				after_travel_reg <= 1'b0;
			end else if (travel_d_reg) begin
				after_travel_reg <= 1'b1;
			end
		end
	end

	// Encoder position difference, computed every cycle
	always @* begin
		diff_now = abs_diff(abs_pos_stored, abs_pos_new);
	end

	// Raw fault events from the monitored inputs
	always @* begin
		event_vec = {`NUM_FAULTS{1'b0}};
		event_vec[`BIT_912] = inverter_operating && !chopper_monitor_closed;
		event_vec[`BIT_913] = dc_expired;
		event_vec[`BIT_914] = startup_check && !startup_d_reg && !encoder_present;
		event_vec[`BIT_916] = travel_active && !encoder_signal_ok;
		event_vec[`BIT_917] = resistor_expired;
		event_vec[`BIT_919] = travel_active && !brake_monitor_input;
		event_vec[`BIT_920] = !travel_active && overcurrent;
		event_vec[`BIT_931] = stage_error;
		event_vec[`BIT_950] = travel_down_counter_at_limit;
		event_vec[`BIT_960] = sto_expired;
		event_vec[`BIT_961] = sto_hw_fail;
		event_vec[`BIT_991] = travel_active && !ipc_ok;
		event_vec[`BIT_993] = startup_check && abs_pos_valid && (diff_now > POS_TOLERANCE);
		event_vec[`BIT_994] = ipc_expired;
		event_vec[`BIT_995] = travel_start_req && !travel_active &&
			(!track_c_in_limit || !track_d_in_limit);
	end

	// Sticky faults hold through a reset request; others drop on it
	always @* begin
		if (!power_on_rst_n) begin
			flags_next = {`NUM_FAULTS{1'b0}};
		end else if (!rst_n) begin
			flags_next = (fault_flags & STICKY_MASK) | (event_vec & STICKY_MASK);
		end else begin
			flags_next = fault_flags | event_vec;
		end
	end

	// Last-travel sequencer: one travel allowed once the limit is hit
	always @* begin
		lt_next = lt_reg;
		case (lt_reg)
			LT_IDLE: begin
				if (travel_down_counter_at_limit) begin
					lt_next = LT_ARMED;
				end
			end
			LT_ARMED: begin
				if (!travel_down_counter_at_limit) begin
					lt_next = LT_IDLE;
				end else if (travel_d_reg && !travel_active) begin
					lt_next = LT_USED;
				end
			end
			LT_USED: begin
				if (!travel_down_counter_at_limit) begin
					lt_next = LT_IDLE;
				end
			end
			default: begin
				lt_next = LT_IDLE;
			end
		endcase
	end

	// Last-travel state re-arms on a reset request: one more travel after reset
	always @(posedge clk) begin
		if (!power_on_rst_n || !rst_n) begin
			lt_reg <= LT_IDLE;
		end else begin
			lt_reg <= lt_next;
		end
	end

	// Fault latch and code; both follow the same next value
	always @(posedge clk) begin
		if (!power_on_rst_n) begin
			fault_flags <= {`NUM_FAULTS{1'b0}};
			fault_code <= `FC_NONE;
		end else begin
			fault_flags <= flags_next;
			fault_code <= code_of(flags_next);
		end
	end

	// Travel inhibit; the limit fault alone still lets the one remaining travel go
	always @(posedge clk) begin
		if (!power_on_rst_n) begin
			travel_inhibit <= 1'b0;
		end else begin
			travel_inhibit <= ((flags_next & ~(15'h0001 << `BIT_950)) != {`NUM_FAULTS{1'b0}}) ||
				(flags_next[`BIT_950] && lt_next == LT_USED);
		end
	end

	// Switch-off follows the latched disagreement fault, so it is sticky too
	always @(posedge clk) begin
		if (!power_on_rst_n) begin
			sto_switch_off <= 1'b0;
		end else begin
			sto_switch_off <= flags_next[`BIT_960];
		end
	end

	// Remaining-travel grant mirrors the armed sequencer state
	always @(posedge clk) begin
		if (!power_on_rst_n) begin
			last_travel_granted <= 1'b0;
		end else begin
			last_travel_granted <= (lt_next == LT_ARMED);
		end
	end

	// Difference kept from the first 993 event; held until a new 993 event once that fault is cleared
	always @(posedge clk) begin
		if (!power_on_rst_n) begin
			pos_diff <= {POS_WIDTH{1'b0}};
		end else if (event_vec[`BIT_993] && !fault_flags[`BIT_993]) begin
			pos_diff <= diff_now;
		end
	end

endmodule

//--- tb/fault_supervisor_chk.sv
/*
 Port assertions for the fatal-fault supervisor.
 Assumes it is bound into fatal_fault_supervisor and shares its port names.
*/
module fault_supervisor_chk (
	// Clock and resets
	input logic clk,
	input logic rst_n,
	input logic power_on_rst_n,
	// Causes
	input logic inverter_operating,
	input logic chopper_monitor_closed,
	input logic travel_active,
	input logic encoder_signal_ok,
	input logic overcurrent,
	input logic stage_error,
	input logic sto_hw_fail,
	input logic ipc_ok,
	// Fault outputs
	input logic [9:0] fault_code,
	input logic [14:0] fault_flags,
	input logic travel_inhibit
);
	// Both resets silence the checks; sticky checks see only power-up
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n || !power_on_rst_n);

	chop_open_a: assert property (
		inverter_operating && !chopper_monitor_closed |=> fault_flags[0]) else $error("chopper fault not raised");
	enc_lost_a: assert property (
		travel_active && !encoder_signal_ok |=> fault_flags[3]) else $error("encoder loss not raised");
	overcur_stand_a: assert property (
		!travel_active && overcurrent |=> fault_flags[6]) else $error("overcurrent fault not raised");
	stage_err_a: assert property (
		stage_error |=> fault_flags[7]) else $error("stage fault not raised");
	sto_hw_a: assert property (
		sto_hw_fail |=> fault_flags[10]) else $error("hardware fault not raised");
	ipc_travel_a: assert property (
		travel_active && !ipc_ok |=> fault_flags[11]) else $error("link fault not raised");
	sticky_hw_a: assert property (disable iff (!power_on_rst_n)
		fault_flags[10] |=> fault_flags[10]) else $error("sticky fault cleared");
	sticky_stage_a: assert property (disable iff (!power_on_rst_n)
		fault_flags[7] |=> fault_flags[7]) else $error("stage fault cleared");
	inhibit_set_a: assert property (
		fault_flags[7] |-> ##[0:1] travel_inhibit) else $error("travel not inhibited");
	code_prio_a: assert property (
		fault_flags[0] |-> ##[0:1] fault_code == 10'h390) else $error("wrong fault code");

	// Main scenarios reached
	cover property (fault_flags[9]);
	cover property (fault_flags[8] && !travel_inhibit);
	cover property (fault_flags[12]);
endmodule

bind fatal_fault_supervisor fault_supervisor_chk chk (.clk(clk), .rst_n(rst_n),
	.power_on_rst_n(power_on_rst_n), .inverter_operating(inverter_operating),
	.chopper_monitor_closed(chopper_monitor_closed), .travel_active(travel_active),
	.encoder_signal_ok(encoder_signal_ok), .overcurrent(overcurrent), .stage_error(stage_error),
	.sto_hw_fail(sto_hw_fail), .ipc_ok(ipc_ok), .fault_code(fault_code), .fault_flags(fault_flags),
	.travel_inhibit(travel_inhibit));

//--- tb/encoder_model.sv
/*
 Behavioural absolute encoder on the encoder port.
 Assumes the bench steers plugging, signal cut, track faults and position shift.
*/
module encoder_model (
	// Bench controls
	input logic plugged,
	input logic signal_cut,
	input logic [1:0] track_bad,
	input logic [23:0] shift,
	// Encoder port
	output logic encoder_present,
	output logic encoder_signal_ok,
	output logic abs_pos_valid,
	output logic [23:0] abs_pos_new,
	output logic track_c_in_limit,
	output logic track_d_in_limit
);
	localparam logic [23:0] HOME = 24'h001000;

	// Unplugged port shows inverted junk, never the last good position
	assign encoder_present = plugged;
	assign encoder_signal_ok = plugged && !signal_cut;
	assign abs_pos_valid = plugged;
	assign abs_pos_new = plugged ? HOME + shift : ~(HOME + shift);
	assign track_c_in_limit = !track_bad[0];
	assign track_d_in_limit = !track_bad[1]; // Either track alone must trip the check
endmodule

//--- tb/drive_fatal_fault_supervisor_tb_top.sv
/*
 Self-checking bench for the fatal-fault supervisor with shortened windows.
 Assumes the checker is bound in and the encoder model sits on the encoder port.
*/
module drive_fatal_fault_supervisor_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, power_on_rst_n, inverter_operating, travel_active, travel_start_req, startup_check;
	logic chopper_monitor_closed, dc_link_above_trigger, braking_resistor_on, brake_monitor_input, overcurrent;
	logic stage_error, encoder_present, encoder_signal_ok, abs_pos_valid, track_c_in_limit, track_d_in_limit;
	logic safe_torque_off_ch_a, safe_torque_off_ch_b, sto_hw_fail, ipc_ok, mgmt_link_ok;
	logic travel_down_counter_at_limit, travel_inhibit, sto_switch_off, last_travel_granted;
	logic plugged, signal_cut;
	logic [1:0] track_bad;
	logic [23:0] abs_pos_new, abs_pos_stored, pos_diff, shift;
	logic [9:0] fault_code;
	logic [14:0] fault_flags;
	logic [14:0] fb [8] = '{15'h0001, 15'h0008, 15'h0020, 15'h0800, 15'h0080, 15'h0040, 15'h0000, 15'h0000};
	logic [9:0] fc [8] = '{10'h390, 10'h394, 10'h397, 10'h3DF, 10'h3A3, 10'h398, 10'h000, 10'h000};
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;

	fatal_fault_supervisor #(.DC_HIGH_CYCLES(20), .RESISTOR_ON_CYCLES(30), .STO_DISAGREE_CYCLES(10),
		.IPC_LOSS_CYCLES(40)) dut (.clk(clk), .rst_n(rst_n), .power_on_rst_n(power_on_rst_n),
		.inverter_operating(inverter_operating), .travel_active(travel_active),
		.travel_start_req(travel_start_req), .startup_check(startup_check),
		.chopper_monitor_closed(chopper_monitor_closed), .dc_link_above_trigger(dc_link_above_trigger),
		.braking_resistor_on(braking_resistor_on), .brake_monitor_input(brake_monitor_input),
		.overcurrent(overcurrent), .stage_error(stage_error), .encoder_present(encoder_present),
		.encoder_signal_ok(encoder_signal_ok), .abs_pos_valid(abs_pos_valid), .abs_pos_new(abs_pos_new),
		.abs_pos_stored(abs_pos_stored), .track_c_in_limit(track_c_in_limit),
		.track_d_in_limit(track_d_in_limit), .safe_torque_off_ch_a(safe_torque_off_ch_a),
		.safe_torque_off_ch_b(safe_torque_off_ch_b), .sto_hw_fail(sto_hw_fail), .ipc_ok(ipc_ok),
		.mgmt_link_ok(mgmt_link_ok), .travel_down_counter_at_limit(travel_down_counter_at_limit),
		.fault_code(fault_code), .fault_flags(fault_flags), .travel_inhibit(travel_inhibit),
		.sto_switch_off(sto_switch_off), .pos_diff(pos_diff), .last_travel_granted(last_travel_granted));
	encoder_model enc (.plugged(plugged), .signal_cut(signal_cut), .track_bad(track_bad), .shift(shift),
		.encoder_present(encoder_present), .encoder_signal_ok(encoder_signal_ok),
		.abs_pos_valid(abs_pos_valid), .abs_pos_new(abs_pos_new), .track_c_in_limit(track_c_in_limit),
		.track_d_in_limit(track_d_in_limit));

	// 10 MHz clock
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end

	task check(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task finish_test;
		$display("Mismatches %0d of %0d comparisons", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task cyc_n(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Healthy plant, standstill
	task defaults;
		inverter_operating = 1;
		travel_active = 0;
		travel_start_req = 0;
		startup_check = 0;
		chopper_monitor_closed = 1;
		dc_link_above_trigger = 0;
		braking_resistor_on = 0;
		brake_monitor_input = 1;
		overcurrent = 0;
		stage_error = 0;
		safe_torque_off_ch_a = 1;
		safe_torque_off_ch_b = 1;
		sto_hw_fail = 0;
		ipc_ok = 1;
		mgmt_link_ok = 1;
		travel_down_counter_at_limit = 0;
		plugged = 1;
		signal_cut = 0;
		track_bad = 0;
		shift = 0;
		abs_pos_stored = 24'h001000;
	endtask

	task do_reset(input logic por);
		rst_n = 0;
		power_on_rst_n = !por;
		cyc_n(2);
		rst_n = 1;
		power_on_rst_n = 1;
		cyc_n(2);
	endtask

	// One-cycle causes; the last two are gated off by state
	task t_pulse;
		for (int i = 0; i < 8; i++) begin
			travel_active = (i < 4 || i == 6);
			case (i)
				0: chopper_monitor_closed = 0;
				1: signal_cut = 1;
				2: brake_monitor_input = 0;
				3: ipc_ok = 0;
				4: stage_error = 1;
				5, 6: overcurrent = 1;
				7: begin
					inverter_operating = 0;
					chopper_monitor_closed = 0;
				end
			endcase
			cyc_n(1);
			defaults();
			cyc_n(1);
			check(fault_flags, fb[i]);
			check(fault_code, fc[i]);
			check(travel_inhibit, |fb[i]);
			do_reset(0);
			check(fault_flags, fb[i] & 15'h0080);
			do_reset(1);
		end
	endtask

	// Timed windows: silent just before the limit, latched just after
	task t_timed(input int k, input int n, input logic [14:0] exp);
		case (k)
			0: dc_link_above_trigger = 1;
			1: begin
				travel_active = 1;
				braking_resistor_on = 1;
				cyc_n(3);
				travel_active = 0;
			end
			2: mgmt_link_ok = 0;
		endcase
		cyc_n(n - 2);
		check(fault_flags, 0);
		cyc_n(6);
		check(fault_flags, exp);
		defaults();
		do_reset(1);
	endtask

	// Channel disagreement with a restart, then stickiness
	task t_sto;
		safe_torque_off_ch_b = 0;
		cyc_n(8);
		safe_torque_off_ch_b = 1;
		cyc_n(1);
		safe_torque_off_ch_b = 0;
		cyc_n(8);
		check(fault_flags, 0);
		cyc_n(6);
		check({sto_switch_off, fault_flags}, 16'h8200);
		sto_hw_fail = 1;
		cyc_n(1);
		defaults();
		do_reset(0);
		check(fault_flags, 15'h0600);
		do_reset(1);
		check(fault_flags, 0);
	endtask

	task startup(input logic p, input logic [23:0] s, input logic [1:0] t);
		plugged = p;
		shift = s;
		track_bad = t;
		travel_start_req = |t;
		startup_check = 1;
		cyc_n(3);
	endtask

	// Encoder checks at startup, tolerance boundary included
	task t_enc;
		startup(0, 0, 0);
		check(fault_flags, 15'h0004);
		defaults();
		do_reset(1);
		startup(1, 24'h000100, 0);
		check(fault_flags, 0);
		defaults();
		do_reset(1);
		startup(1, 24'h000101, 2'b01);
		check(fault_flags, 15'h5000);
		check(pos_diff, 24'h000101);
		defaults();
		do_reset(0);
		check(fault_flags, 15'h4000);
		do_reset(1);
		startup(1, 24'h000000, 2'b10);
		check(fault_flags, 15'h4000);
		defaults();
		do_reset(1);
	endtask

	// Counter at limit: one travel left, again after a reset request
	task t_limit;
		travel_down_counter_at_limit = 1;
		cyc_n(2);
		check({last_travel_granted, travel_inhibit, fault_flags}, 17'h10100);
		travel_active = 1;
		cyc_n(2);
		travel_active = 0;
		cyc_n(2);
		check({last_travel_granted, travel_inhibit, fault_flags}, 17'h08100);
		do_reset(0);
		cyc_n(1);
		check({last_travel_granted, travel_inhibit, fault_flags}, 17'h10100);
	endtask

	// Main sequence
	initial begin
		defaults();
		do_reset(1);
		t_pulse();
		t_timed(0, 20, 15'h0002);
		t_timed(1, 30, 15'h0010);
		t_timed(2, 40, 15'h2000);
		t_sto();
		t_enc();
		t_limit();
		finish_test();
	end

	// Hang guard, far above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			finish_test();
		end
	end
endmodule
